// ### design/tmr_pkg.sv
// Package: register map, field layout and bus carriers of the 16-bit timer
package tmr_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets (one aligned word each)
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CNT_LO   = 8'h00;
    localparam logic [7:0]  OFS_CNT_HI   = 8'h04;
    localparam logic [7:0]  OFS_CAP_LO   = 8'h08;
    localparam logic [7:0]  OFS_CAP_HI   = 8'h0C;
    localparam logic [7:0]  OFS_CMPA_LO  = 8'h10;
    localparam logic [7:0]  OFS_CMPA_HI  = 8'h14;
    localparam logic [7:0]  OFS_CMPB_LO  = 8'h18;
    localparam logic [7:0]  OFS_CMPB_HI  = 8'h1C;
    localparam logic [7:0]  OFS_CTRL_A   = 8'h20;
    localparam logic [7:0]  OFS_CTRL_B   = 8'h24;
    localparam logic [7:0]  OFS_FLAGS    = 8'h28;
    localparam logic [7:0]  OFS_MASK     = 8'h2C;
    localparam logic [7:0]  OFS_CMP_CTRL = 8'h30;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          CTRLB_FILT   = 7;  // capture_filter_enable
    localparam int          CTRLB_EDGE   = 6;  // 1 = rising edge captures
    localparam int          CTRLB_WGM_LO = 3;  // mode bits 3:2 at [4:3]
    localparam int          FLG_OVF      = 0;  // overflow_flag
    localparam int          FLG_CAP      = 5;  // capture_flag
    localparam int          CMPC_SEL     = 2;  // comparator_capture_select

    // ----------------------------------------------------------------
    // Reset values and constants
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_16       = 16'h0000;
    localparam logic [7:0]  RST_8        = 8'h00;
    localparam logic [15:0] MAX_16       = 16'hFFFF;
    localparam logic [9:0]  RST_PRESC    = 10'h000;
    localparam int          FILT_LEN     = 4;

    // Clock source codes
    localparam logic [2:0]  CS_STOP      = 3'h0;
    localparam logic [2:0]  CS_DIV1      = 3'h1;
    localparam logic [2:0]  CS_DIV8      = 3'h2;
    localparam logic [2:0]  CS_DIV64     = 3'h3;
    localparam logic [2:0]  CS_DIV256    = 3'h4;
    localparam logic [2:0]  CS_DIV1024   = 3'h5;
    localparam logic [2:0]  CS_EXT_FALL  = 3'h6;

    // Count direction
    typedef enum logic {
        DIR_UP,
        DIR_DOWN
    } tmr_dir_e;

    // APB request and answer
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } tmr_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tmr_apb_rsp_s;

    // Event inputs and interrupt acknowledges
    typedef struct packed {
        logic capture_input_pin;
        logic comparator_output;
        logic external_count_pin;
    } tmr_pins_s;

    typedef struct packed {
        logic ack_capture;
        logic ack_overflow;
    } tmr_ack_s;

    typedef struct packed {
        logic capture_irq;
        logic overflow_irq;
    } tmr_irq_s;

endpackage : tmr_pkg

// ### design/tmr_counter_capture.sv
// Module: 16-bit timer with byte-wise access, counter and input capture
`timescale 1ns/1ps
`default_nettype none

module tmr_counter_capture (
    // Clock, reset, enable
    input  wire  logic                 pclk,
    input  wire  logic                 presetn,
    input  wire  logic                 ce,
    // APB slave
    input  wire  tmr_pkg::tmr_apb_req_s apb_req,
    output var   tmr_pkg::tmr_apb_rsp_s apb_rsp,
    // Event pins and interrupt service
    input  wire  tmr_pkg::tmr_pins_s   pins,
    input  wire  tmr_pkg::tmr_ack_s    ack,
    output var   tmr_pkg::tmr_irq_s    irq
);
    import tmr_pkg::*;

    // ----------------------------------------------------------------
    // Operation notes
    // ----------------------------------------------------------------
    // Zero wait states; pready for one cycle
    // Read side effects at setup, writes at access
    // High bytes of counter and capture via latch
    // Compare high bytes read directly
    // Latch loads on low reads of counter, capture
    // Low writes commit latch and byte at once
    // Split byte pairs corrupt the shared latch
    // Unmapped or unaligned places: pslverr
    // Capture: sync, optional filter, edge detect
    // Filter runs on pclk, not on the prescaler
    // Filter adds four cycles of delay
    // Edge select: 1 rising, 0 falling
    // Filter and edge blind in ceiling modes
    // Capture writes only in ceiling modes
    // Each capture overwrites the last value
    // Source change can fake an edge; clear flag
    // Free prescaler: first tick may come early
    // Clock select zero stops counting only
    // Codes 6 and 7 count external pin edges
    // Counter write beats that edge's count step
    // Dual slope: overflow at bottom
    // Single slope: overflow at top or past MAX; modes 4 and 12 only at MAX
    // Flag set wins over a clear in one cycle
    // Interrupt lines track the next flag image
    // ce low freezes every flop, bus answer too
    // Limitation: no compare outputs or buffering
    // Limitation: single slope counter above ceiling runs to MAX

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        // Counter, stored values and shared latch
        logic [15:0]   cnt;
        logic [15:0]   cap;
        logic [15:0]   cmpa;
        logic [15:0]   cmpb;
        logic [7:0]    tmp;
        // Software control and flags
        logic [7:0]    ctrl_a;
        logic [7:0]    ctrl_b;
        logic [7:0]    flags;
        logic [7:0]    mask;
        logic [7:0]    cmp_ctrl;
        // Count machinery
        tmr_dir_e      dir;
        logic [9:0]    presc;
        logic [1:0]    ext_sync;
        logic          ext_prev;
        // Capture path; filter keeps three past samples
        logic [1:0]    icp_sync;
        logic [1:0]    aco_sync;
        logic [FILT_LEN-2:0] filt;
        logic          filt_out;
        logic          edge_prev;
        // Registered outputs
        tmr_apb_rsp_s  rsp;
        tmr_irq_s      irq;
    } tmr_state_s;

    tmr_state_s r;
    tmr_state_s next_r;

    // ----------------------------------------------------------------
    // Decoded mode
    // ----------------------------------------------------------------
    // Mode decode
    logic [3:0]  wgm;
    logic [2:0]  cs;
    logic [15:0] top;
    logic        icr_top;
    logic        dual;
    logic        clr_top;

    // Tick and capture path
    logic        tick;
    logic        ovf_set;
    logic        trig;
    logic        filt_in;
    logic        edge_in;
    logic        cap_evt;

    // Bus decode
    logic        acc;
    logic        setup;
    logic        wr;
    logic [7:0]  wbyte;
    logic [7:0]  a;

    // Mode field split over both control registers
    assign wgm = {r.ctrl_b[CTRLB_WGM_LO+1:CTRLB_WGM_LO], r.ctrl_a[1:0]};
    assign cs  = r.ctrl_b[2:0];
    assign a   = apb_req.paddr;

    // Ceiling of the count sequence per mode
    // Modes 0 and 13 never clear at a ceiling
    always_comb begin
        icr_top = 1'b0;
        dual    = 1'b0;
        clr_top = 1'b1;
        top     = MAX_16;
        unique case (wgm)
            4'd1, 4'd5:   top = 16'h00FF;
            4'd2, 4'd6:   top = 16'h01FF;
            4'd3, 4'd7:   top = 16'h03FF;
            4'd4, 4'd9, 4'd11, 4'd15: top = r.cmpa;
            4'd8, 4'd10, 4'd12, 4'd14: begin
                top     = r.cap;
                icr_top = 1'b1;
            end
            default:      top = MAX_16;
        endcase
        if (wgm inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11}) begin
            dual = 1'b1;
        end
        if (wgm == 4'd0 || wgm == 4'd13) begin
            clr_top = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Timer tick
    // ----------------------------------------------------------------
    // Tick select; prescaler taps chosen by low-bit patterns
    // Default branch is code 7, external rising
    always_comb begin
        unique case (cs)
            CS_STOP:     tick = 1'b0;
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = &r.presc[2:0];
            CS_DIV64:    tick = &r.presc[5:0];
            CS_DIV256:   tick = &r.presc[7:0];
            CS_DIV1024:  tick = &r.presc[9:0];
            CS_EXT_FALL: tick = r.ext_prev & ~r.ext_sync[1];
            default:     tick = ~r.ext_prev & r.ext_sync[1];
        endcase
    end

    // ----------------------------------------------------------------
    // Capture path
    // ----------------------------------------------------------------
    // Trigger source, filter and edge detector
    // Source switched after sync so a change can itself look like an edge
    assign trig    = r.cmp_ctrl[CMPC_SEL] ? r.aco_sync[1] : r.icp_sync[1];
    assign filt_in = trig; // Newest of four filter samples
    assign edge_in = r.ctrl_b[CTRLB_FILT] ? r.filt_out : trig;
    assign cap_evt = !icr_top && (edge_in != r.edge_prev)
                   && (edge_in == r.ctrl_b[CTRLB_EDGE]);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // Bus phases
    assign setup = apb_req.psel & ~apb_req.penable;
    assign acc   = apb_req.psel & apb_req.penable & r.rsp.pready;
    assign wr    = acc & apb_req.pwrite;
    assign wbyte = apb_req.pwdata[7:0];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        ovf_set = 1'b0;

        // Free prescaler and two-flop synchronisers
        next_r.presc    = r.presc + 10'd1;
        next_r.ext_sync = {r.ext_sync[0], pins.external_count_pin};
        next_r.ext_prev = r.ext_sync[1];
        next_r.icp_sync = {r.icp_sync[0], pins.capture_input_pin};
        next_r.aco_sync = {r.aco_sync[0], pins.comparator_output};

        // Filter samples every pclk, independent of prescaler
        next_r.filt = {filt_in, r.filt[FILT_LEN-2:1]};
        // Newest sample plus three stored keeps the delay at four cycles
        if ({filt_in, r.filt} == {FILT_LEN{filt_in}}) begin
            next_r.filt_out = filt_in;
        end
        next_r.edge_prev = edge_in;

        // Count sequence
        // Dual slope turns at the ceiling and reports at the bottom
        // Overflow only noted here; applied after all clears below
        if (tick) begin
            if (dual) begin
                if (r.dir == DIR_UP) begin
                    if (r.cnt >= top) begin
                        next_r.dir = DIR_DOWN;
                        next_r.cnt = r.cnt - 16'd1;
                    end else begin
                        next_r.cnt = r.cnt + 16'd1;
                    end
                end else if (r.cnt == RST_16) begin
                    next_r.dir          = DIR_UP;
                    next_r.cnt          = r.cnt + 16'd1;
                    ovf_set             = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 16'd1;
                end
            end else if (clr_top && r.cnt == top) begin
                next_r.cnt = RST_16;
                if ((wgm != 4'd4 && wgm != 4'd12) || r.cnt == MAX_16) begin
                    ovf_set = 1'b1;
                end
            end else begin
                next_r.cnt = r.cnt + 16'd1;
                if (r.cnt == MAX_16) begin
                    ovf_set = 1'b1;
                end
            end
        end

        // Answer prepared in setup; low reads load the latch there
        // Unmapped or unaligned places answer pslverr and read zero
        next_r.rsp.pready = 1'b0;
        if (setup) begin
            next_r.rsp.pready  = 1'b1;
            next_r.rsp.pslverr = 1'b0;
            next_r.rsp.prdata  = 32'h0000_0000;
            unique case (a)
                OFS_CNT_LO: begin
                    next_r.rsp.prdata[7:0] = r.cnt[7:0];
                    if (!apb_req.pwrite) begin
                        next_r.tmp = r.cnt[15:8];
                    end
                end
                OFS_CAP_LO: begin
                    next_r.rsp.prdata[7:0] = r.cap[7:0];
                    if (!apb_req.pwrite) begin
                        next_r.tmp = r.cap[15:8];
                    end
                end
                OFS_CNT_HI, OFS_CAP_HI: next_r.rsp.prdata[7:0] = r.tmp;
                OFS_CMPA_LO:  next_r.rsp.prdata[7:0] = r.cmpa[7:0];
                OFS_CMPA_HI:  next_r.rsp.prdata[7:0] = r.cmpa[15:8];
                OFS_CMPB_LO:  next_r.rsp.prdata[7:0] = r.cmpb[7:0];
                OFS_CMPB_HI:  next_r.rsp.prdata[7:0] = r.cmpb[15:8];
                OFS_CTRL_A:   next_r.rsp.prdata[7:0] = r.ctrl_a;
                OFS_CTRL_B:   next_r.rsp.prdata[7:0] = r.ctrl_b;
                OFS_FLAGS:    next_r.rsp.prdata[7:0] = r.flags;
                OFS_MASK:     next_r.rsp.prdata[7:0] = r.mask;
                OFS_CMP_CTRL: next_r.rsp.prdata[7:0] = r.cmp_ctrl;
                default:      next_r.rsp.pslverr = 1'b1;
            endcase
        end

        // Capture overwrites unconditionally
        if (cap_evt) begin
            next_r.cap = r.cnt;
        end

        // Writes take effect at the access edge
        // Capture low write dropped outside ceiling modes
        if (wr) begin
            unique case (a)
                OFS_CNT_HI, OFS_CAP_HI, OFS_CMPA_HI, OFS_CMPB_HI: begin
                    next_r.tmp = wbyte;
                end
                OFS_CNT_LO: begin
                    next_r.cnt = {r.tmp, wbyte};
                end
                OFS_CAP_LO: begin
                    if (icr_top) begin
                        next_r.cap = {r.tmp, wbyte};
                    end
                end
                OFS_CMPA_LO:  next_r.cmpa     = {r.tmp, wbyte};
                OFS_CMPB_LO:  next_r.cmpb     = {r.tmp, wbyte};
                OFS_CTRL_A:   next_r.ctrl_a   = wbyte;
                OFS_CTRL_B:   next_r.ctrl_b   = wbyte;
                OFS_MASK:     next_r.mask     = wbyte;
                OFS_CMP_CTRL: next_r.cmp_ctrl = wbyte;
                OFS_FLAGS:    next_r.flags    = r.flags & ~wbyte;
                default:      next_r.tmp      = r.tmp;
            endcase
        end

        // Service acknowledges clear flags
        if (ack.ack_capture) begin
            next_r.flags[FLG_CAP] = 1'b0;
        end
        if (ack.ack_overflow) begin
            next_r.flags[FLG_OVF] = 1'b0;
        end

        // Set beats clear, same cycle as the copy
        if (cap_evt) begin
            next_r.flags[FLG_CAP] = 1'b1;
        end
        if (ovf_set) begin
            next_r.flags[FLG_OVF] = 1'b1;
        end

        // Requests registered from the next flag image
        next_r.irq.capture_irq  = next_r.flags[FLG_CAP] & next_r.mask[FLG_CAP];
        next_r.irq.overflow_irq = next_r.flags[FLG_OVF] & next_r.mask[FLG_OVF];
    end

    // ----------------------------------------------------------------
    // State register; ce low freezes everything
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Constants only in the reset branch
            r          <= '0;
            r.dir      <= DIR_UP;
            r.cnt      <= RST_16;
            r.cap      <= RST_16;
            r.tmp      <= RST_8;
            r.ctrl_b   <= RST_8;
            r.presc    <= RST_PRESC;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Outputs straight from state flops
    assign apb_rsp = r.rsp;
    assign irq     = r.irq;

endmodule : tmr_counter_capture

`default_nettype wire

// ### verification/tmr_cc_monitor.sv
// Checker for bus answers, shared latch, capture flag and reset state
`timescale 1ns/1ps
`default_nettype none
module tmr_cc_monitor (
    // Clock, reset, enable
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  ce,
    // Bus, pins and interrupt service
    input wire tmr_pkg::tmr_apb_req_s apb_req,
    input wire tmr_pkg::tmr_apb_rsp_s apb_rsp,
    input wire tmr_pkg::tmr_pins_s    pins,
    input wire tmr_pkg::tmr_ack_s     ack,
    input wire tmr_pkg::tmr_irq_s     irq
);
    import tmr_pkg::*;
    logic [4:0] calm;
    logic       known;
    logic [7:0] lat;
    // Bus phase decode
    wire logic go  = apb_req.psel && !apb_req.penable && ce;
    wire logic fin = apb_req.psel && apb_req.penable && apb_rsp.pready && ce;
    wire logic hi  = apb_req.paddr < 8'h20 && apb_req.paddr[2:0] == 3'h4;
    wire logic lo  = apb_req.paddr == OFS_CNT_LO || apb_req.paddr == OFS_CAP_LO;
    // Quiet time since a trigger moved or software used the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calm  <= 5'h00;
            known <= 1'b0;
            lat   <= 8'h00;
        end else begin
            calm <= (pins[2:1] != $past(pins[2:1]) || apb_req.psel) ? 5'h00
                  : calm + {4'h0, calm != 5'h1F};
            // Shadow of the shared latch, lost once a low read reloads it
            if (fin && apb_req.pwrite && hi) begin
                known <= 1'b1;
                lat   <= apb_req.pwdata[7:0];
            end else if (go && !apb_req.pwrite && lo) begin
                known <= 1'b0;
            end
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_hi_read;
        go && !apb_req.pwrite && hi && !apb_req.paddr[4] && known;
    endsequence
    sequence s_ack_quiet;
        ack.ack_capture && ce && calm > 5'd20 ##1 ce;
    endsequence
    a_setup_answer: assert property (go |=> apb_rsp.pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (apb_rsp.pready && ce |=> !apb_rsp.pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (go && (apb_req.paddr > OFS_CMP_CTRL
        || apb_req.paddr[1:0] != 2'h0) |=> apb_rsp.pslverr)
        else $error("bad address not refused");
    a_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_latch_read: assert property (s_hi_read |=> apb_rsp.prdata[7:0] == lat)
        else $error("high byte read bypassed latch");
    a_reset_quiet: assert property (!$past(presetn) |-> irq == 2'b00)
        else $error("interrupt active after reset");
    a_cap_cause: assert property ($rose(irq.capture_irq) |-> calm < 5'd20)
        else $error("capture without trigger");
    a_ack_clears: assert property (s_ack_quiet |=> !irq.capture_irq)
        else $error("capture flag kept after service");
endmodule : tmr_cc_monitor
bind tmr_counter_capture tmr_cc_monitor i_tmr_cc_monitor (
    .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .pins(pins), .ack(ack), .irq(irq)
);
`default_nettype wire

// ### verification/tmr_evt_src.sv
// Event source model for the capture, comparator and count pins
`timescale 1ns/1ps
`default_nettype none
module tmr_evt_src (
    // Clock and requested levels
    input  wire logic               pclk,
    input  wire logic [2:0]         lvl,
    input  wire logic [3:0]         spike,
    // Pins seen by the timer
    output var  tmr_pkg::tmr_pins_s pins
);
    logic [3:0] left = 4'h0;
    logic       inv  = 1'b0;
    // A spike inverts the capture pin for exactly that many cycles
    always @(posedge pclk) begin
        inv  <= spike != 4'h0 || left > 4'h1;
        left <= (spike != 4'h0) ? spike : left - {3'h0, left != 4'h0};
    end
    // Driven level acts like an outside event
    assign pins = {lvl[2] ^ inv, lvl[1:0]};
endmodule : tmr_evt_src
`default_nettype wire

// ### verification/tmr_counter_capture_tb.sv
// Testbench for the 16-bit timer with byte access and input capture
`timescale 1ns/1ps
`default_nettype none
module tmr_counter_capture_tb;
    import tmr_pkg::*;
    typedef struct {logic err; logic chk; logic [31:0] v;} tmr_exp_s;
    logic         pclk = 1'b0;
    logic         presetn;
    logic         ce;
    tmr_apb_req_s req;
    tmr_apb_rsp_s rsp;
    tmr_pins_s    pins;
    tmr_ack_s     ack;
    tmr_irq_s     irq;
    logic [2:0]   lvl;
    logic [3:0]   spike;
    logic [31:0]  rd;
    logic [31:0]  seed = 32'd15543;
    logic [7:0]   v;
    int           mismatches = 0;
    int           n_checks = 0;
    tmr_exp_s     q[$];
    tmr_exp_s     ex;
    tmr_counter_capture i_tmr_counter_capture (.pclk(pclk), .presetn(presetn), .ce(ce),
        .apb_req(req), .apb_rsp(rsp), .pins(pins), .ack(ack), .irq(irq));
    tmr_evt_src i_tmr_evt_src (.pclk(pclk), .lvl(lvl), .spike(spike), .pins(pins));
    always #50 pclk = ~pclk;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask : wait_n
    // One transfer; refusal expected for unmapped or unaligned places
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        input logic c, input logic [7:0] e);
        q.push_back('{a > OFS_CMP_CTRL || a[1:0] != 2'h0, c, {24'h0, e}});
        req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        req <= '{1'b0, 1'b0, w, a, 32'h0};
        @(posedge pclk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b0, 8'h00);
    endtask : wr
    task automatic rd8(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00, 1'b1, e);
    endtask : rd8
    task automatic spk(input logic [3:0] n);
        spike <= n;
        @(posedge pclk);
        spike <= 4'h0;
        wait_n(25);
    endtask : spk
    task automatic ack_pulse(input logic c);
        ack <= {c, !c};
        @(posedge pclk);
        ack <= 2'b00;
        wait_n(2);
    endtask : ack_pulse
    task automatic ext_pulses(input int n);
        repeat (n) begin
            lvl[0] <= 1'b1;
            wait_n(4);
            lvl[0] <= 1'b0;
            wait_n(4);
        end
    endtask : ext_pulses
    // Completed transfers are held against the oldest note
    always @(posedge pclk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1) begin
            ex = q.pop_front();
            check("pslverr", {31'h0, rsp.pslverr}, {31'h0, ex.err});
            if (ex.chk) check("prdata", rsp.prdata, ex.v);
        end
    end
    initial begin
        wait_n(20000);
        mismatches++;
        end_sim();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        lvl = 3'h0;
        spike = 4'h0;
        ack = 2'b00;
        req = '0;
        wait_n(3);
        presetn <= 1'b1;
        @(posedge pclk);
        rd8(OFS_CNT_LO, 8'h00);
        rd8(OFS_FLAGS, 8'h00);
        wr(OFS_CNT_HI, 8'h01);
        wr(OFS_CNT_LO, 8'hFF);
        rd8(OFS_CNT_HI, 8'h01);
        rd8(OFS_CNT_LO, 8'hFF);
        rd8(OFS_CNT_HI, 8'h01);
        wr(OFS_CMPA_HI, 8'hAB);
        wr(OFS_CMPA_LO, 8'h56);
        wr(OFS_CNT_LO, 8'h34);
        wr(OFS_CNT_HI, 8'h00);
        rd8(OFS_CMPA_HI, 8'hAB);
        rd8(OFS_CNT_LO, 8'h34);
        rd8(OFS_CNT_HI, 8'hAB);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(OFS_CMPB_HI, seed[15:8]);
            wr(OFS_CMPB_LO, seed[7:0]);
            wr(OFS_CNT_HI, ~seed[15:8]);
            rd8(OFS_CMPB_HI, seed[15:8]);
        end
        xfer(1'b0, 8'h40, 8'h00, 1'b1, 8'h00);
        wr(8'h22, 8'hFF);
        rd8(OFS_CTRL_A, 8'h00);
        // Run near the top at full rate and see the wrap
        wr(OFS_MASK, 8'h21);
        wr(OFS_CNT_HI, 8'hFF);
        wr(OFS_CNT_LO, 8'hF0);
        wr(OFS_CTRL_B, {5'h0, CS_DIV1});
        wait_n(30);
        check("overflow_irq", {31'h0, irq.overflow_irq}, 32'h1);
        rd8(OFS_FLAGS, 8'h01);
        wr(OFS_CNT_HI, 8'h80);
        wr(OFS_CNT_LO, 8'h00);
        wr(OFS_CTRL_B, 8'h00);
        xfer(1'b0, OFS_CNT_LO, 8'h00, 1'b0, 8'h00);
        v = rd[7:0];
        rd8(OFS_CNT_HI, 8'h80);
        ce <= 1'b0;
        wait_n(5);
        ce <= 1'b1;
        rd8(OFS_CNT_LO, v);
        ack_pulse(1'b0);
        rd8(OFS_FLAGS, 8'h00);
        // External count pin, five rising edges
        wr(OFS_CTRL_B, 8'h07);
        ext_pulses(5);
        wr(OFS_CTRL_B, 8'h00);
        rd8(OFS_CNT_LO, v + 8'h05);
        // Dual slope 8-bit: FD FE FF then down to FC, no bottom reached
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_CNT_HI, 8'h00);
        wr(OFS_CNT_LO, 8'hFD);
        wr(OFS_CTRL_B, 8'h07);
        ext_pulses(5);
        wr(OFS_CTRL_B, 8'h00);
        wr(OFS_CTRL_A, 8'h00);
        rd8(OFS_CNT_LO, 8'hFC);
        rd8(OFS_FLAGS, 8'h00);
        // Rising pin edge captures the stopped counter
        wr(OFS_CNT_HI, 8'h12);
        wr(OFS_CNT_LO, 8'h34);
        wr(OFS_CTRL_B, 8'h40);
        lvl[2] <= 1'b1;
        wait_n(25);
        wr(OFS_CNT_HI, 8'h56);
        wr(OFS_CNT_LO, 8'h78);
        rd8(OFS_CAP_LO, 8'h34);
        rd8(OFS_CAP_HI, 8'h12);
        wr(OFS_CAP_HI, 8'h99);
        wr(OFS_CAP_LO, 8'h77);
        rd8(OFS_CAP_LO, 8'h34);
        wait_n(25);
        check("capture_irq", {31'h0, irq.capture_irq}, 32'h1);
        ack_pulse(1'b1);
        check("capture_irq", {31'h0, irq.capture_irq}, 32'h0);
        lvl[2] <= 1'b0;
        wait_n(25);
        rd8(OFS_FLAGS, 8'h00);
        lvl[2] <= 1'b1;
        wait_n(25);
        rd8(OFS_CAP_LO, 8'h78);
        wr(OFS_FLAGS, 8'h20);
        rd8(OFS_FLAGS, 8'h00);
        // Comparator as trigger source
        wr(OFS_CMP_CTRL, 8'h04);
        wait_n(25);
        wr(OFS_FLAGS, 8'h20);
        lvl[1] <= 1'b1;
        wait_n(25);
        rd8(OFS_FLAGS, 8'h20);
        wr(OFS_CMP_CTRL, 8'h00);
        wait_n(25);
        wr(OFS_FLAGS, 8'h20);
        // Filter: short spike ignored, longer pulse taken
        wr(OFS_CTRL_B, 8'hC0);
        lvl[2] <= 1'b0;
        wait_n(25);
        spk(4'h3);
        rd8(OFS_FLAGS, 8'h00);
        spk(4'h6);
        rd8(OFS_FLAGS, 8'h20);
        // Ceiling mode: capture writable, trigger off
        wr(OFS_FLAGS, 8'h20);
        wr(OFS_CTRL_B, 8'h18);
        wr(OFS_CAP_HI, 8'h22);
        wr(OFS_CAP_LO, 8'h33);
        spk(4'h6);
        rd8(OFS_FLAGS, 8'h00);
        rd8(OFS_CAP_LO, 8'h33);
        rd8(OFS_CAP_HI, 8'h22);
        presetn <= 1'b0;
        wait_n(2);
        presetn <= 1'b1;
        @(posedge pclk);
        rd8(OFS_CAP_LO, 8'h00);
        end_sim();
    end
endmodule : tmr_counter_capture_tb
`default_nettype wire
